// ### core/opfc_chain.sv
// opfc_chain: predistortion filter chains, one per waveform output, between generator and converter.
// assumes all control inputs come from logic on clk, which is the filter clock.
//
// Operation
// - one independent chain per output channel, own settings and status
// - chain holds eight exponential, one high-pass, one bounce, one FIR stage
// - chain enable low makes the output equal the input one cycle later, whole chain bypassed
// - every stage has its own enable, independent of the others
// - enabled chain has a base latency of nine filter clock cycles
// - filter clock is one eighth of sample rate, eight samples per cycle
// - each enabled stage adds its fixed latency, a disabled one adds none
// - total path latency for the present enables is reported
// - live overflow flag per stage while overflow is present
// - sticky overflow flag per stage remembers past overflow
// - one clear request clears the sticky overflow flags of all stages of a chain
// - overflow when an output sample reaches the converter code limit
// - FIR stage programmable, kernel spans thirty nanoseconds of samples
// - sequencer clear before playback resets filter history
// - high-pass stage adds twelve cycles when enabled
// - each exponential stage adds eleven cycles when enabled
// - high-pass clear follows playback: level, start, end or both
module opfc_chain
  import opfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_CH-1:0] chainEnable,
  input wire logic [NUM_CH-1:0][NUM_STG-1:0] stageEnable,
  input wire opfc_coef_t [NUM_CH-1:0][NUM_EXP-1:0][2:0] expCoef,
  input wire opfc_coef_t [NUM_CH-1:0][2:0] hpCoef,
  input wire opfc_coef_t [NUM_CH-1:0] bounceAmp,
  input wire opfc_coef_t [NUM_CH-1:0][FIR_TAPS-1:0] firCoef,
  input wire opfc_clear_mode_t [NUM_CH-1:0] clearMode,
  input wire logic [NUM_CH-1:0] filter_clear_request,
  input wire logic [NUM_CH-1:0] playbackStart,
  input wire logic [NUM_CH-1:0] playbackEnd,
  input wire logic [NUM_CH-1:0] statusClear,
  input wire opfc_group_t [NUM_CH-1:0] dataIn,
  output opfc_group_t [NUM_CH-1:0] dataOut,
  output logic [NUM_CH-1:0][NUM_STG-1:0] overflowLive,
  output logic [NUM_CH-1:0][NUM_STG-1:0] overflowSticky,
  output logic [NUM_CH-1:0][LAT_W-1:0] latency,
  output logic [NUM_CH-1:0] hpClearActive
);

  typedef struct packed {
    opfc_group_t [NUM_CH-1:0][BASE_REGS-1:0] base;
    opfc_group_t [NUM_CH-1:0] out;
    logic [NUM_CH-1:0][NUM_STG-1:0] live;
    logic [NUM_CH-1:0][NUM_STG-1:0] sticky;
    logic [NUM_CH-1:0][LAT_W-1:0] lat;
    opfc_clear_state_t [NUM_CH-1:0] clrState;
    logic [NUM_CH-1:0] hpClr;
    logic [NUM_CH-1:0] allClr;
  } opfc_top_state_t;

  opfc_top_state_t s;
  opfc_top_state_t next_s;

  opfc_group_t chainOut [NUM_CH];
  logic [NUM_STG-1:0] stageOvf [NUM_CH];

  //////////////////////////////////////////////////////////////////////////////
  // one chain per channel, stages in series: exponential, high-pass, bounce, FIR
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire opfc_group_t [NUM_STG:0] link;
    wire logic [NUM_STG-1:0] ovf;

    assign link[0] = dataIn[c];

    for (genvar e = 0; e < NUM_EXP; e++) begin : g_exp
      opfc_iir_stage #(
        .LAT(int'(LAT_EXP)),
        .BOUNCE(1'b0)
      ) u_exp (
        .clk(clk),
        .rst(rst),
        .enable(stageEnable[c][e]),
        .clear(s.allClr[c]),
        .b0(expCoef[c][e][COEF_B0]),
        .b1(expCoef[c][e][COEF_B1]),
        .a1(expCoef[c][e][COEF_A1]),
        .dataIn(link[e]),
        .dataOut(link[e+1]),
        .overflow(ovf[e])
      );
    end

    // integrating stage, cleared on the timing chosen by clearMode
    opfc_iir_stage #(
      .LAT(int'(LAT_HP)),
      .BOUNCE(1'b0)
    ) u_hp (
      .clk(clk),
      .rst(rst),
      .enable(stageEnable[c][STG_HP]),
      .clear(s.hpClr[c]),
      .b0(hpCoef[c][COEF_B0]),
      .b1(hpCoef[c][COEF_B1]),
      .a1(hpCoef[c][COEF_A1]),
      .dataIn(link[STG_HP]),
      .dataOut(link[STG_HP+1]),
      .overflow(ovf[STG_HP])
    );

    opfc_iir_stage #(
      .LAT(int'(LAT_BNC)),
      .BOUNCE(1'b1)
    ) u_bnc (
      .clk(clk),
      .rst(rst),
      .enable(stageEnable[c][STG_BNC]),
      .clear(s.allClr[c]),
      .b0(bounceAmp[c]),
      .b1('0),
      .a1('0),
      .dataIn(link[STG_BNC]),
      .dataOut(link[STG_BNC+1]),
      .overflow(ovf[STG_BNC])
    );

    opfc_fir_stage u_fir (
      .clk(clk),
      .rst(rst),
      .enable(stageEnable[c][STG_FIR]),
      .clear(s.allClr[c]),
      .coef(firCoef[c]),
      .dataIn(link[STG_FIR]),
      .dataOut(link[STG_FIR+1]),
      .overflow(ovf[STG_FIR])
    );

    assign chainOut[c] = link[NUM_STG];
    assign stageOvf[c] = ovf;
  end

  //////////////////////////////////////////////////////////////////////////////
  // base delay, bypass, latency sum, overflow flags and clear sequencing
  always_comb begin
    logic [LAT_W-1:0] sum;
    sum = '0;
    next_s = s;
    for (int c = 0; c < NUM_CH; c++) begin
      // base pipeline: BASE_REGS stages plus the output register
      next_s.base[c][0] = chainOut[c];
      for (int k = 1; k < BASE_REGS; k++) begin
        next_s.base[c][k] = s.base[c][k-1];
      end
      // bypass keeps one register so outputs always come from a flop
      next_s.out[c] = chainEnable[c] ? s.base[c][BASE_REGS-1] : dataIn[c];

      // latency of the current enable pattern
      sum = LAT_BASE;
      for (int k = 0; k < NUM_STG; k++) begin
        if (stageEnable[c][k]) begin
          sum = sum + opfc_stage_lat(k);
        end
      end
      next_s.lat[c] = chainEnable[c] ? sum : LAT_BYPASS;

      // flags only count while the chain is in the path
      next_s.live[c] = chainEnable[c] ? stageOvf[c] : '0;
      // new overflow wins over a clear in the same cycle
      next_s.sticky[c] = (statusClear[c] ? '0 : s.sticky[c]) | next_s.live[c];

      // clear request arms; the next playback carries the clear
      next_s.allClr[c] = 1'b0;
      next_s.hpClr[c] = 1'b0;
      unique case (s.clrState[c])
        OPFC_IDLE: begin
          if (filter_clear_request[c]) begin
            next_s.clrState[c] = OPFC_ARMED;
          end
        end
        OPFC_ARMED: begin
          if (playbackStart[c]) begin
            next_s.clrState[c] = OPFC_PLAY;
            next_s.allClr[c] = 1'b1;
            next_s.hpClr[c] = (clearMode[c] != OPFC_CLR_FALL);
          end
        end
        OPFC_PLAY: begin
          if (playbackEnd[c]) begin
            next_s.clrState[c] = filter_clear_request[c] ? OPFC_ARMED : OPFC_IDLE;
            next_s.hpClr[c] = (clearMode[c] == OPFC_CLR_FALL) || (clearMode[c] == OPFC_CLR_BOTH);
          end else begin
            next_s.hpClr[c] = (clearMode[c] == OPFC_CLR_LEVEL);
          end
        end
        default: begin
          next_s.clrState[c] = OPFC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // all outputs straight from the state register
  assign dataOut = s.out;
  assign overflowLive = s.live;
  assign overflowSticky = s.sticky;
  assign latency = s.lat;
  assign hpClearActive = s.hpClr;

endmodule : opfc_chain

// ### core/opfc_fir_stage.sv
// opfc_fir_stage: programmable FIR over a kernel of FIR_TAPS samples, eight outputs per cycle.
// assumes the kernel is loaded while the stage is disabled or the stream is idle.
module opfc_fir_stage
  import opfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clear,
  input wire opfc_coef_t [FIR_TAPS-1:0] coef,
  input wire opfc_group_t dataIn,
  output opfc_group_t dataOut,
  output logic overflow
);

  typedef struct packed {
    opfc_group_t [FIR_HIST-1:0] hist;
    opfc_group_t out;
    logic ovf;
  } opfc_fir_state_t;

  opfc_fir_state_t s;
  opfc_fir_state_t next_s;

  //////////////////////////////////////////////////////////////////////////////
  // full convolution per lane; wide but keeps latency at one cycle
  always_comb begin
    opfc_sample_t win [FIR_HIST*LANES+LANES];
    opfc_acc_t acc;
    opfc_group_t grp;
    logic hit;
    win = '{default: '0};
    acc = '0;
    grp = '0;
    hit = 1'b0;
    next_s = s;
    for (int g = 0; g < FIR_HIST; g++) begin
      for (int i = 0; i < LANES; i++) begin
        win[g*LANES+i] = s.hist[g][i];
      end
    end
    for (int i = 0; i < LANES; i++) begin
      win[FIR_HIST*LANES+i] = dataIn[i];
    end
    for (int i = 0; i < LANES; i++) begin
      acc = '0;
      for (int k = 0; k < FIR_TAPS; k++) begin
        acc = acc + opfc_acc_t'(coef[k]) * opfc_acc_t'(win[FIR_HIST*LANES+i-k]);
      end
      grp[i] = opfc_sat(acc >>> COEF_FRAC);
      hit = hit | opfc_at_limit(grp[i]);
    end
    // history shifts one group per cycle, oldest at index 0
    for (int g = 0; g < FIR_HIST-1; g++) begin
      next_s.hist[g] = s.hist[g+1];
    end
    next_s.hist[FIR_HIST-1] = dataIn;
    next_s.out = grp;
    next_s.ovf = hit;
    if (clear || !enable) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dataOut = enable ? s.out : dataIn;
  assign overflow = s.ovf;

endmodule : opfc_fir_stage

// ### core/opfc_iir_stage.sv
// opfc_iir_stage: one first-order recursive stage (exponential or high-pass) or a bounce stage.
// assumes coefficients stay steady while the stage runs; clear and enable come from the same clock.
module opfc_iir_stage
  import opfc_pkg::*;
#(
  parameter int LAT = 11,
  parameter bit BOUNCE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clear,
  input wire opfc_coef_t b0,
  input wire opfc_coef_t b1,
  input wire opfc_coef_t a1,
  input wire opfc_group_t dataIn,
  output opfc_group_t dataOut,
  output logic overflow
);

  typedef struct packed {
    opfc_sample_t xPrev;
    opfc_sample_t yPrev;
    opfc_group_t yGrp;
    opfc_group_t [LAT-1:0] line;
    logic ovf;
  } opfc_iir_state_t;

  opfc_iir_state_t s;
  opfc_iir_state_t next_s;

  //////////////////////////////////////////////////////////////////////////////
  // eight samples resolved in series so the recursion sees every sample in order
  always_comb begin
    opfc_acc_t acc;
    opfc_sample_t xp;
    opfc_sample_t yp;
    opfc_sample_t y;
    opfc_group_t grp;
    logic hit;
    acc = '0;
    xp = s.xPrev;
    yp = s.yPrev;
    y = '0;
    grp = '0;
    hit = 1'b0;
    next_s = s;
    for (int i = 0; i < LANES; i++) begin
      if (BOUNCE) begin
        // reflection term taken from one group back, a delay of eight samples
        acc = (opfc_acc_t'(dataIn[i]) <<< COEF_FRAC) + opfc_acc_t'(b0) * opfc_acc_t'(s.yGrp[i]);
      end else begin
        acc = opfc_acc_t'(b0) * opfc_acc_t'(dataIn[i]) + opfc_acc_t'(b1) * opfc_acc_t'(xp)
              - opfc_acc_t'(a1) * opfc_acc_t'(yp);
      end
      y = opfc_sat(acc >>> COEF_FRAC);
      hit = hit | opfc_at_limit(y);
      xp = dataIn[i];
      yp = y;
      grp[i] = y;
    end
    next_s.xPrev = xp;
    next_s.yPrev = yp;
    next_s.yGrp = grp;
    next_s.ovf = hit;
    // fixed pipeline gives this stage its own latency
    next_s.line[0] = grp;
    for (int k = 1; k < LAT; k++) begin
      next_s.line[k] = s.line[k-1];
    end
    // history dropped on clear; disabled stage holds no state
    if (clear || !enable) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // disabled stage forwards the stream untouched and adds no delay
  assign dataOut = enable ? s.line[LAT-1] : dataIn;
  assign overflow = s.ovf;

endmodule : opfc_iir_stage

// ### include/opfc_pkg.sv
// opfc_pkg: constants, types and helpers shared by the output predistortion filter chain.
// assumes one filter clock carrying groups of eight consecutive converter samples per cycle.
package opfc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // sample stream geometry
  localparam int NUM_CH = 4;            // waveform output channels
  localparam int LANES = 8;             // samples per filter clock cycle
  localparam int SAMPLE_W = 16;         // converter code width
  localparam int COEF_W = 16;           // coefficient width
  localparam int COEF_FRAC = 14;        // coefficient fraction bits
  localparam int ACC_W = 40;            // accumulator width

  //////////////////////////////////////////////////////////////////////////////
  // stage order inside one chain: eight exponential, high-pass, bounce, FIR
  localparam int NUM_EXP = 8;
  localparam int NUM_STG = 11;
  localparam int STG_HP = 8;
  localparam int STG_BNC = 9;
  localparam int STG_FIR = 10;
  localparam int COEF_B0 = 0;
  localparam int COEF_B1 = 1;
  localparam int COEF_A1 = 2;

  //////////////////////////////////////////////////////////////////////////////
  // latencies in filter clock cycles
  localparam int LAT_W = 8;
  localparam logic [LAT_W-1:0] LAT_BASE = 8'h09;
  localparam logic [LAT_W-1:0] LAT_EXP = 8'h0B;
  localparam logic [LAT_W-1:0] LAT_HP = 8'h0C;
  localparam logic [LAT_W-1:0] LAT_BNC = 8'h01;
  localparam logic [LAT_W-1:0] LAT_FIR = 8'h01;
  localparam logic [LAT_W-1:0] LAT_BYPASS = 8'h01;
  localparam int BASE_REGS = int'(LAT_BASE) - 1;  // output register supplies the last cycle

  //////////////////////////////////////////////////////////////////////////////
  // FIR kernel span derived from its length in time and the sample rate
  localparam int FIR_LEN_NS = 30;
  localparam int SAMPLE_RATE_MHZ = 2400;
  localparam int FIR_TAPS = (FIR_LEN_NS * SAMPLE_RATE_MHZ) / 1000;
  localparam int FIR_HIST = FIR_TAPS / LANES;

  //////////////////////////////////////////////////////////////////////////////
  // converter range limits
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 16'h7FFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 16'h8000;

  typedef logic signed [SAMPLE_W-1:0] opfc_sample_t;
  typedef logic signed [COEF_W-1:0] opfc_coef_t;
  typedef logic signed [ACC_W-1:0] opfc_acc_t;
  typedef opfc_sample_t [LANES-1:0] opfc_group_t;

  // when the high-pass clear is issued relative to the playback
  typedef enum logic [1:0] {
    OPFC_CLR_LEVEL,
    OPFC_CLR_RISE,
    OPFC_CLR_FALL,
    OPFC_CLR_BOTH
  } opfc_clear_mode_t;

  typedef enum logic [1:0] {
    OPFC_IDLE,
    OPFC_ARMED,
    OPFC_PLAY
  } opfc_clear_state_t;

  // clamp a scaled accumulator to the converter range
  function automatic opfc_sample_t opfc_sat(input opfc_acc_t v);
    if (v > opfc_acc_t'(SAMPLE_MAX)) begin
      return SAMPLE_MAX;
    end else if (v < opfc_acc_t'(SAMPLE_MIN)) begin
      return SAMPLE_MIN;
    end
    return v[SAMPLE_W-1:0];
  endfunction : opfc_sat

  function automatic logic opfc_at_limit(input opfc_sample_t s);
    return (s == SAMPLE_MAX) || (s == SAMPLE_MIN);
  endfunction : opfc_at_limit

  function automatic logic [LAT_W-1:0] opfc_stage_lat(input int idx);
    if (idx == STG_HP) begin
      return LAT_HP;
    end else if (idx == STG_BNC) begin
      return LAT_BNC;
    end else if (idx == STG_FIR) begin
      return LAT_FIR;
    end
    return LAT_EXP;
  endfunction : opfc_stage_lat

endpackage : opfc_pkg

// ### sim/opfc_chain_props.sv
// opfc_chain_props: timing and status checks on channel 0 of the filter chain.
// assumes it is bound to opfc_chain and sees only its ports.
module opfc_chain_props
  import opfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_CH-1:0] chainEnable,
  input wire logic [NUM_CH-1:0][NUM_STG-1:0] stageEnable,
  input wire opfc_coef_t [NUM_CH-1:0][NUM_EXP-1:0][2:0] expCoef,
  input wire opfc_coef_t [NUM_CH-1:0][2:0] hpCoef,
  input wire opfc_coef_t [NUM_CH-1:0] bounceAmp,
  input wire opfc_coef_t [NUM_CH-1:0][FIR_TAPS-1:0] firCoef,
  input wire opfc_clear_mode_t [NUM_CH-1:0] clearMode,
  input wire logic [NUM_CH-1:0] filter_clear_request,
  input wire logic [NUM_CH-1:0] playbackStart,
  input wire logic [NUM_CH-1:0] playbackEnd,
  input wire logic [NUM_CH-1:0] statusClear,
  input wire opfc_group_t [NUM_CH-1:0] dataIn,
  input wire opfc_group_t [NUM_CH-1:0] dataOut,
  input wire logic [NUM_CH-1:0][NUM_STG-1:0] overflowLive,
  input wire logic [NUM_CH-1:0][NUM_STG-1:0] overflowSticky,
  input wire logic [NUM_CH-1:0][LAT_W-1:0] latency,
  input wire logic [NUM_CH-1:0] hpClearActive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAT_W-1:0] expLat;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // latency expected from the enables, worked from the stage figures
  always_comb begin
    expLat = 8'h09 + (stageEnable[0][STG_HP] ? 8'h0C : 8'h00) + (stageEnable[0][STG_BNC] ? LAT_BNC : 8'h00);
    expLat = expLat + (stageEnable[0][STG_FIR] ? LAT_FIR : 8'h00);
    for (int i = 0; i < NUM_EXP; i++) begin
      expLat = expLat + (stageEnable[0][i] ? 8'h0B : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_bypass_data: assert property (!chainEnable[0] |=> dataOut[0] == $past(dataIn[0]))
    else $error("bypass output differs from input");
  a_bypass_latency: assert property (!chainEnable[0] |=> latency[0] == LAT_BYPASS)
    else $error("bypass latency wrong");
  a_latency_sum: assert property (chainEnable[0] |=> latency[0] == $past(expLat))
    else $error("enabled latency wrong");
  a_live_gated: assert property (!chainEnable[0] [*3] |-> overflowLive[0] == '0)
    else $error("live flag while bypassed");
  a_stage_quiet: assert property (!stageEnable[0][0] [*3] |-> !overflowLive[0][0])
    else $error("disabled stage flags overflow");
  a_sticky_cover: assert property ((overflowLive[0] & ~overflowSticky[0]) == '0)
    else $error("live flag without sticky flag");
  a_sticky_hold: assert property (overflowSticky[0][0] && !statusClear[0] |=> overflowSticky[0][0])
    else $error("sticky flag lost");
  a_sticky_clear: assert property ((!chainEnable[0] && stageEnable[0] == '0) [*3] ##0 statusClear[0]
    |=> overflowSticky[0] == '0) else $error("sticky flags not cleared");
  a_hp_rise: assert property ($past(filter_clear_request[0], 2) && playbackStart[0]
    && clearMode[0] == OPFC_CLR_RISE |=> hpClearActive[0] ##1 !hpClearActive[0]) else $error("rise clear wrong");
  a_hp_level: assert property ($past(filter_clear_request[0], 2) && playbackStart[0]
    && clearMode[0] == OPFC_CLR_LEVEL |=> hpClearActive[0] [*4]) else $error("level clear dropped");
  a_hp_fall: assert property (playbackEnd[0] && $past(playbackStart[0], 4) && $past(filter_clear_request[0], 6)
    && clearMode[0] == OPFC_CLR_FALL |=> hpClearActive[0] ##1 !hpClearActive[0]) else $error("fall clear wrong");
endmodule : opfc_chain_props

// ### sim/opfc_wave_source.sv
// opfc_wave_source: waveform generator and sequencer model ahead of the chain.
// assumes the bench raises go for one falling edge to run one clear playback.
module opfc_wave_source
  import opfc_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic ramp,
  input wire opfc_sample_t level,
  output opfc_group_t data,
  output logic clrReq,
  output logic start,
  output logic stop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] seq = 4'h0;
  logic [11:0] cnt = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // steps on the falling edge, well away from the sampling edge
  always @(negedge clk) begin
    cnt <= cnt + 12'h001;
    seq <= go ? 4'h1 : (seq == 4'h0 || seq == 4'h8) ? 4'h0 : seq + 4'h1;
  end

  // ramp keeps every group distinct so a wrong delay shows
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      data[i] = ramp ? opfc_sample_t'({cnt, i[2:0]}) : level;
    end
  end

  // clear request comes two cycles ahead of its playback
  assign clrReq = (seq == 4'h1);
  assign start = (seq == 4'h3);
  assign stop = (seq == 4'h7);
endmodule : opfc_wave_source

// ### sim/testbench.sv
// testbench: directed tests of the predistortion filter chain.
// assumes unity coefficients make every stage a pure delay.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import opfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_CH-1:0] chainEnable = '0;
  logic [NUM_CH-1:0][NUM_STG-1:0] stageEnable = '0;
  opfc_coef_t [NUM_CH-1:0][NUM_EXP-1:0][2:0] expCoef;
  opfc_coef_t [NUM_CH-1:0][2:0] hpCoef;
  opfc_coef_t [NUM_CH-1:0][FIR_TAPS-1:0] firCoef;
  opfc_clear_mode_t [NUM_CH-1:0] clearMode;
  logic [NUM_CH-1:0] statusClear = '0;
  logic go = 1'b0;
  logic ramp = 1'b1;
  opfc_sample_t level = '0;
  logic clrReq, start, stop;
  opfc_group_t srcData;
  opfc_group_t [NUM_CH-1:0] dataOut;
  logic [NUM_CH-1:0][NUM_STG-1:0] overflowLive, overflowSticky;
  logic [NUM_CH-1:0][LAT_W-1:0] latency;
  logic [NUM_CH-1:0] hpClearActive;
  opfc_group_t hist [128];
  logic [6:0] cyc = '0;
  logic [9:0] rec;
  logic [9:0] hpExp [4] = '{10'h03C, 10'h004, 10'h040, 10'h044};
  int bad_count = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  opfc_wave_source i_src (.clk(clk), .go(go), .ramp(ramp), .level(level), .data(srcData),
    .clrReq(clrReq), .start(start), .stop(stop));
  opfc_chain i_dut (.clk(clk), .rst(rst), .chainEnable(chainEnable), .stageEnable(stageEnable),
    .expCoef(expCoef), .hpCoef(hpCoef), .bounceAmp('0), .firCoef(firCoef), .clearMode(clearMode),
    .filter_clear_request({NUM_CH{clrReq}}), .playbackStart({NUM_CH{start}}), .playbackEnd({NUM_CH{stop}}),
    .statusClear(statusClear), .dataIn({NUM_CH{srcData}}), .dataOut(dataOut), .overflowLive(overflowLive),
    .overflowSticky(overflowSticky), .latency(latency), .hpClearActive(hpClearActive));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a record of every group the chain took
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    hist[cyc] = srcData;
    cyc = cyc + 7'h01;
  end

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // output now must equal the group taken lat edges ago
  task automatic chk_path(input int ch, input logic [6:0] lat);
    chk("dataOut", dataOut[ch], hist[cyc - lat]);
  endtask : chk_path

  task automatic clear_status();
    statusClear <= 4'h1;
    repeat (1) @(negedge clk);
    statusClear <= 4'h0;
    repeat (3) @(negedge clk);
  endtask : clear_status

  function automatic logic [7:0] stg_lat(input int k);
    return k < 8 ? 8'h0B : k == 8 ? 8'h0C : k == 9 ? LAT_BNC : LAT_FIR;
  endfunction : stg_lat

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // a hang is cut off well past the expected run of about 830 cycles
  initial begin
    #20000;
    bad_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    expCoef = '0;
    hpCoef = '0;
    firCoef = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      clearMode[c] = OPFC_CLR_LEVEL;
      for (int s = 0; s < NUM_EXP; s++) expCoef[c][s][COEF_B0] = 16'h4000;
      hpCoef[c][COEF_B0] = 16'h4000;
      firCoef[c][0] = 16'h4000;
    end
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    // channel 0 in path, the others bypassed
    chainEnable <= 4'h1;
    repeat (20) @(negedge clk);
    chk("latency0", latency[0], 8'h09);
    chk("latency1", latency[1], LAT_BYPASS);
    chk_path(0, 7'h09);
    chk_path(1, 7'h01);
    $display("test bypass done");
    // one stage at a time, then all of them
    for (int k = 0; k < NUM_STG; k++) begin
      stageEnable[0] <= 11'h001 << k;
      repeat (40) @(negedge clk);
      chk("latency0", latency[0], 8'h09 + stg_lat(k));
      chk_path(0, 7'(8'h09 + stg_lat(k)));
    end
    stageEnable[0] <= 11'h7FF;
    repeat (130) @(negedge clk);
    chk("latency0", latency[0], 8'h6F);
    chk_path(0, 7'h6F);
    // kernel moved to tap eight delays the stream by one more group
    stageEnable[0] <= 11'h400;
    firCoef[0][0] <= 16'h0000;
    firCoef[0][8] <= 16'h4000;
    repeat (30) @(negedge clk);
    chk_path(0, 7'h0B);
    firCoef[0][0] <= 16'h4000;
    firCoef[0][8] <= 16'h0000;
    $display("test latency done");
    // gain near two drives the first stage past the positive limit
    stageEnable[0] <= 11'h001;
    ramp <= 1'b0;
    level <= 16'h6000;
    expCoef[0][0][COEF_B0] <= 16'h7FFF;
    repeat (30) @(negedge clk);
    chk("dataOut0", dataOut[0][0], 16'h7FFF);
    chk("live0", overflowLive[0], 11'h001);
    level <= 16'h0100;
    repeat (30) @(negedge clk);
    chk("live0", overflowLive[0], 11'h000);
    chk("sticky0", overflowSticky[0], 11'h001);
    clear_status();
    chk("sticky0", overflowSticky[0], 11'h000);
    // unity gain on the negative limit code still counts
    expCoef[0][0][COEF_B0] <= 16'h4000;
    level <= 16'h8000;
    repeat (30) @(negedge clk);
    chk("sticky0", overflowSticky[0], 11'h001);
    level <= 16'h0000;
    repeat (30) @(negedge clk);
    chainEnable <= 4'h0;
    stageEnable[0] <= '0;
    repeat (5) @(negedge clk);
    clear_status();
    chk("sticky0", overflowSticky[0], 11'h000);
    $display("test overflow done");
    // every clear timing mode on a sequencer playback
    chainEnable <= 4'h1;
    stageEnable[0] <= 11'h100;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < NUM_CH; c++) clearMode[c] <= opfc_clear_mode_t'(m);
      go <= 1'b1;
      repeat (1) @(negedge clk);
      go <= 1'b0;
      for (int j = 0; j < 10; j++) begin
        @(negedge clk);
        rec[j] = hpClearActive[0];
      end
      chk("hpClear", rec, hpExp[m]);
      repeat (4) @(negedge clk);
    end
    $display("test clear done");
    test_done();
  end
endmodule : testbench

bind opfc_chain opfc_chain_props i_props (.*);
